/* pkg/eq_loop_pkg.sv */
// Purpose: Shared constants for the equalizer and loop-through configuration bank
// Assumes: APB byte addresses are four times the register index
// Notes: Indices 0x70 and 0x71 hold port targeting and block status
package eq_loop_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int EQ_W = 6;
  localparam int LEVEL_W = 4;

  // Register indices; byte address is index times four
  localparam logic [7:0] IDX_EQ_MANUAL_OVERRIDE = 8'h44;
  localparam logic [7:0] IDX_EQ_FLOOR_CONFIG = 8'h45;
  localparam logic [7:0] IDX_MONITOR_SOURCE_SEL_A = 8'h52;
  localparam logic [7:0] IDX_MONITOR_DRIVER_CTL = 8'h56;
  localparam logic [7:0] IDX_MONITOR_SOURCE_SEL_B = 8'h57;
  localparam logic [7:0] IDX_MONITOR_TX_POWER = 8'h63;
  localparam logic [7:0] IDX_PORT_TARGET = 8'h70;
  localparam logic [7:0] IDX_BLOCK_STATUS = 8'h71;
  localparam logic [1:0] ADDR_LSB = 2'h2;

  // Reset values
  localparam logic [7:0] RST_EQ_MANUAL_OVERRIDE = 8'h60;
  localparam logic [7:0] RST_EQ_FLOOR_CONFIG = 8'h88;
  localparam logic [7:0] RST_MONITOR_SOURCE_SEL_A = 8'h00;
  localparam logic [7:0] RST_MONITOR_DRIVER_CTL = 8'h00;
  localparam logic [7:0] RST_MONITOR_SOURCE_SEL_B = 8'h00;
  localparam logic [7:0] RST_MONITOR_TX_POWER = 8'h00;
  localparam logic [7:0] RST_PORT_TARGET = 8'h00;

  // Field positions
  localparam int POS_EQ_AUTO_OFF = 0;
  localparam int POS_MANUAL_LOW_LSB = 1;
  localparam int POS_MANUAL_HIGH_LSB = 5;
  localparam int POS_START_LEVEL_LSB = 0;
  localparam int POS_MONITOR_SOURCE_BIT = 7;
  localparam int POS_MONITOR_SOURCE_CODE_LSB = 1;
  localparam int POS_MONITOR_DRIVER_ON = 3;
  localparam int POS_MONITOR_TX_SLEEP = 0;
  localparam int POS_SECOND_PORT_TARGET = 0;
  localparam int POS_STAT_AUTO_RUN = 0;
  localparam int POS_STAT_MONITOR_LIVE = 1;
  localparam int POS_STAT_SOURCE_MISMATCH = 2;
  localparam int POS_STAT_SECOND_SOURCE = 3;
  localparam int POS_STAT_TX_SLEEP = 4;

  // Monitor source codes
  localparam logic [1:0] CODE_FIRST_INPUT = 2'h1;
  localparam logic [1:0] CODE_SECOND_INPUT = 2'h2;

  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_ANSWER = 2'b01
  } apb_phase_e;

endpackage : eq_loop_pkg

/* src/eq_and_loop_through_config.sv */
// Purpose: Equalizer and loop-through monitor configuration bank behind an APB slave
// Assumes: Recovered link data arrive on pclk; software keeps the two source selects agreed
// Notes: One wait state on every access; outputs are all registered
//
// Notes on behaviour
// [R1] When the override bit is 1 the automatic equalizer is stopped, when 0 it keeps running.
// [R2] Manual low bits 3-1 form equalizer setting bits 2-0, applied only while overridden.
// [R3] Manual high bits form equalizer setting bits 5-3, applied only while overridden.
// [R4] Each adaptation starts from the four-bit start level, which resets to 8h.
// [R5] Start-level writes go to the second port's copy while the second-port target is set.
// [R6] Source bit 7 at 0 sends first link input data to the monitor, at 1 the second.
// [R7] Source code 01 names the first link input and 10 the second.
// [R8] Software keeps the single source bit and the two-bit code naming the same port.
// [R9] The monitor driver is off after reset and runs only once enable bit 3 is set.
// [R10] Power-down bit 0 at 1 puts the monitor transmitter to sleep, at 0 keeps it powered.
// [R11] Software puts the monitor transmitter to sleep before starting the pattern generator.
// [R12] Read-write fields, reserved bits included, read back as written and reset as printed.
`timescale 1ns/10ps

module eq_and_loop_through_config #(
  parameter int LINK_W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [eq_loop_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [eq_loop_pkg::DATA_W-1:0] pwdata,
  output logic [eq_loop_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [LINK_W-1:0] first_link_input,
  input wire logic [LINK_W-1:0] second_link_input,
  input wire logic adaptation_restart,
  output logic eq_auto_run,
  output logic eq_manual_apply,
  output logic [eq_loop_pkg::EQ_W-1:0] eq_manual_setting,
  output logic [eq_loop_pkg::LEVEL_W-1:0] first_port_start_level,
  output logic [eq_loop_pkg::LEVEL_W-1:0] second_port_start_level,
  output logic first_port_adapt_load,
  output logic second_port_adapt_load,
  output logic [LINK_W-1:0] loop_through_output,
  output logic monitor_driver_on,
  output logic monitor_tx_sleep
);

  localparam int REG_W = eq_loop_pkg::REG_W;
  localparam int DATA_W = eq_loop_pkg::DATA_W;
  // Split of the six-bit manual setting into its two three-bit halves
  localparam int LOW_W = 3;
  localparam int HIGH_W = 3;
  localparam int LOW_TOP = LOW_W - 1;
  localparam int HIGH_TOP = LOW_W + HIGH_W - 1;

  // Index match on an aligned word; low address bits must be zero
  function automatic logic reg_hit(input logic [eq_loop_pkg::ADDR_W-1:0] addr,
                                   input logic [7:0] idx);
    reg_hit = (addr[eq_loop_pkg::ADDR_LSB-1:0] == '0) &&
              (addr[eq_loop_pkg::ADDR_W-1:eq_loop_pkg::ADDR_LSB] ==
               {{(eq_loop_pkg::ADDR_W-eq_loop_pkg::ADDR_LSB-8){1'b0}}, idx});
  endfunction : reg_hit

  // True when the two-bit code is one of the two legal port codes
  function automatic logic code_legal(input logic [1:0] code);
    code_legal = (code == eq_loop_pkg::CODE_FIRST_INPUT) ||
                 (code == eq_loop_pkg::CODE_SECOND_INPUT);
  endfunction : code_legal

  eq_loop_pkg::apb_phase_e phase;
  logic [REG_W-1:0] eq_manual_override;
  logic [REG_W-1:0] eq_floor_first;
  logic [REG_W-1:0] eq_floor_second;
  logic [REG_W-1:0] monitor_source_sel_a;
  logic [REG_W-1:0] monitor_driver_ctl;
  logic [REG_W-1:0] monitor_source_sel_b;
  logic [REG_W-1:0] monitor_tx_power;
  logic [REG_W-1:0] port_target;
  logic [REG_W-1:0] block_status;
  logic [REG_W-1:0] next_rdata;
  logic next_err;
  logic mapped;
  logic write_now;
  logic eq_auto_off;
  logic second_port_target;
  logic monitor_source_bit;
  logic [1:0] monitor_source_code;
  logic source_agree;
  logic monitor_live;
  logic floor_write;
  logic hit_override;
  logic hit_source_a;
  logic hit_driver;
  logic hit_source_b;
  logic hit_tx_power;
  logic hit_port_target;

  // Write takes effect only at the edge where the access phase sees pready high
  assign write_now = psel && penable && pready && pwrite && mapped;

  assign eq_auto_off = eq_manual_override[eq_loop_pkg::POS_EQ_AUTO_OFF];
  assign second_port_target = port_target[eq_loop_pkg::POS_SECOND_PORT_TARGET];
  assign monitor_source_bit = monitor_source_sel_a[eq_loop_pkg::POS_MONITOR_SOURCE_BIT];
  assign monitor_source_code =
    monitor_source_sel_b[eq_loop_pkg::POS_MONITOR_SOURCE_CODE_LSB +: 2];
  // Bit and code must name the same port
  assign source_agree = code_legal(monitor_source_code) &&
    ((monitor_source_code == eq_loop_pkg::CODE_SECOND_INPUT) == monitor_source_bit); // R8
  // Driver stays silent on a disagreeing selection rather than send the wrong port
  assign monitor_live = monitor_driver_ctl[eq_loop_pkg::POS_MONITOR_DRIVER_ON] &&
    !monitor_tx_power[eq_loop_pkg::POS_MONITOR_TX_SLEEP] && source_agree; // R9
  assign floor_write = write_now && reg_hit(paddr, eq_loop_pkg::IDX_EQ_FLOOR_CONFIG);

  // Write decode, one match per stored register
  assign hit_override = reg_hit(paddr, eq_loop_pkg::IDX_EQ_MANUAL_OVERRIDE);
  assign hit_source_a = reg_hit(paddr, eq_loop_pkg::IDX_MONITOR_SOURCE_SEL_A);
  assign hit_driver = reg_hit(paddr, eq_loop_pkg::IDX_MONITOR_DRIVER_CTL);
  assign hit_source_b = reg_hit(paddr, eq_loop_pkg::IDX_MONITOR_SOURCE_SEL_B);
  assign hit_tx_power = reg_hit(paddr, eq_loop_pkg::IDX_MONITOR_TX_POWER);
  assign hit_port_target = reg_hit(paddr, eq_loop_pkg::IDX_PORT_TARGET);

  always_comb begin
    block_status = '0;
    block_status[eq_loop_pkg::POS_STAT_AUTO_RUN] = !eq_auto_off;
    block_status[eq_loop_pkg::POS_STAT_MONITOR_LIVE] = monitor_live;
    block_status[eq_loop_pkg::POS_STAT_SOURCE_MISMATCH] = !source_agree;
    block_status[eq_loop_pkg::POS_STAT_SECOND_SOURCE] = monitor_source_bit;
    block_status[eq_loop_pkg::POS_STAT_TX_SLEEP] =
      monitor_tx_power[eq_loop_pkg::POS_MONITOR_TX_SLEEP];
  end

  // Address decode and read mux
  always_comb begin
    mapped = 1'b1;
    next_rdata = '0;
    if (reg_hit(paddr, eq_loop_pkg::IDX_EQ_MANUAL_OVERRIDE)) begin
      next_rdata = eq_manual_override; // R12
    end else if (reg_hit(paddr, eq_loop_pkg::IDX_EQ_FLOOR_CONFIG)) begin
      next_rdata = second_port_target ? eq_floor_second : eq_floor_first; // R5
    end else if (reg_hit(paddr, eq_loop_pkg::IDX_MONITOR_SOURCE_SEL_A)) begin
      next_rdata = monitor_source_sel_a;
    end else if (reg_hit(paddr, eq_loop_pkg::IDX_MONITOR_DRIVER_CTL)) begin
      next_rdata = monitor_driver_ctl;
    end else if (reg_hit(paddr, eq_loop_pkg::IDX_MONITOR_SOURCE_SEL_B)) begin
      next_rdata = monitor_source_sel_b;
    end else if (reg_hit(paddr, eq_loop_pkg::IDX_MONITOR_TX_POWER)) begin
      next_rdata = monitor_tx_power;
    end else if (reg_hit(paddr, eq_loop_pkg::IDX_PORT_TARGET)) begin
      next_rdata = port_target;
    end else if (reg_hit(paddr, eq_loop_pkg::IDX_BLOCK_STATUS)) begin
      next_rdata = block_status;
    end else begin
      mapped = 1'b0;
    end
  end

  // Status is read-only; writing it is refused like an unmapped address
  always_comb begin
    next_err = !mapped || (pwrite && reg_hit(paddr, eq_loop_pkg::IDX_BLOCK_STATUS));
  end

  // APB handshake: one wait state, answer registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= eq_loop_pkg::APB_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      unique case (phase)
        eq_loop_pkg::APB_IDLE: begin
          pready <= 1'b0;
          pslverr <= 1'b0;
          if (psel && penable) begin
            phase <= eq_loop_pkg::APB_ANSWER;
            pready <= 1'b1;
            pslverr <= next_err;
            prdata <= pwrite ? '0 : {{(DATA_W-REG_W){1'b0}}, next_rdata};
          end
        end
        eq_loop_pkg::APB_ANSWER: begin
          phase <= eq_loop_pkg::APB_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
        default: begin
          phase <= eq_loop_pkg::APB_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
      endcase
    end
  end

  // Register storage, one process per register; whole byte kept so reserved bits read back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eq_manual_override <= eq_loop_pkg::RST_EQ_MANUAL_OVERRIDE; // R12
    end else if (write_now && hit_override) begin
      eq_manual_override <= pwdata[REG_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_source_sel_a <= eq_loop_pkg::RST_MONITOR_SOURCE_SEL_A;
    end else if (write_now && hit_source_a) begin
      monitor_source_sel_a <= pwdata[REG_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_driver_ctl <= eq_loop_pkg::RST_MONITOR_DRIVER_CTL; // R9
    end else if (write_now && hit_driver) begin
      monitor_driver_ctl <= pwdata[REG_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_source_sel_b <= eq_loop_pkg::RST_MONITOR_SOURCE_SEL_B;
    end else if (write_now && hit_source_b) begin
      monitor_source_sel_b <= pwdata[REG_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_tx_power <= eq_loop_pkg::RST_MONITOR_TX_POWER; // R10
    end else if (write_now && hit_tx_power) begin
      monitor_tx_power <= pwdata[REG_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_target <= eq_loop_pkg::RST_PORT_TARGET;
    end else if (write_now && hit_port_target) begin
      port_target <= pwdata[REG_W-1:0];
    end
  end

  // Start level has one copy per link port; the target bit steers the write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eq_floor_first <= eq_loop_pkg::RST_EQ_FLOOR_CONFIG; // R4
      eq_floor_second <= eq_loop_pkg::RST_EQ_FLOOR_CONFIG;
    end else if (floor_write) begin
      if (second_port_target) begin
        eq_floor_second <= pwdata[REG_W-1:0]; // R5
      end else begin
        eq_floor_first <= pwdata[REG_W-1:0];
      end
    end
  end

  // Equalizer mode toward the link receivers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eq_auto_run <= 1'b0;
      eq_manual_apply <= 1'b0;
    end else begin
      eq_auto_run <= !eq_auto_off; // R1
      eq_manual_apply <= eq_auto_off; // R1
    end
  end

  // Manual setting, low half from bits 3-1 and high half from bits 7-5
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eq_manual_setting <= '0;
    end else if (eq_auto_off) begin
      eq_manual_setting[LOW_TOP:0] <=
        eq_manual_override[eq_loop_pkg::POS_MANUAL_LOW_LSB +: LOW_W]; // R2
      eq_manual_setting[HIGH_TOP:LOW_W] <=
        eq_manual_override[eq_loop_pkg::POS_MANUAL_HIGH_LSB +: HIGH_W]; // R3
    end else begin
      // Zero while adapting so a stale manual value never leaks to the receiver
      eq_manual_setting <= '0;
    end
  end

  // Adaptation start levels; a load pulse marks each new adaptation start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_port_start_level <= '0;
      second_port_start_level <= '0;
      first_port_adapt_load <= 1'b0;
      second_port_adapt_load <= 1'b0;
    end else begin
      first_port_start_level <=
        eq_floor_first[eq_loop_pkg::POS_START_LEVEL_LSB +: eq_loop_pkg::LEVEL_W]; // R4
      second_port_start_level <=
        eq_floor_second[eq_loop_pkg::POS_START_LEVEL_LSB +: eq_loop_pkg::LEVEL_W];
      first_port_adapt_load <= !eq_auto_off &&
        (adaptation_restart || (floor_write && !second_port_target)); // R4
      second_port_adapt_load <= !eq_auto_off &&
        (adaptation_restart || (floor_write && second_port_target)); // R5
    end
  end

  // Loop-through monitor path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_tx_sleep <= 1'b0;
    end else begin
      monitor_tx_sleep <= monitor_tx_power[eq_loop_pkg::POS_MONITOR_TX_SLEEP]; // R10
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_driver_on <= 1'b0; // R9
    end else begin
      monitor_driver_on <= monitor_live; // R9
    end
  end

  // Muted rather than stale data while the monitor is not live
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_through_output <= '0;
    end else if (!monitor_live) begin
      loop_through_output <= '0;
    end else if (monitor_source_code == eq_loop_pkg::CODE_SECOND_INPUT) begin
      loop_through_output <= second_link_input; // R7
    end else begin
      loop_through_output <= monitor_source_bit ? second_link_input : first_link_input; // R6
    end
  end

endmodule : eq_and_loop_through_config

/* tb/eq_loop_properties.sv */
// Purpose: Port-level checks for the equalizer and loop-through bank
// Assumes: One pclk domain, asynchronous active-low reset
// Notes: Monitor data is only checked as one of the two inputs once the driver has been on two cycles running, and as zero while it is off
`timescale 1ns/10ps
module eq_loop_properties #(
  parameter int LINK_W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [LINK_W-1:0] first_link_input,
  input wire logic [LINK_W-1:0] second_link_input,
  input wire logic adaptation_restart,
  input wire logic eq_auto_run,
  input wire logic eq_manual_apply,
  input wire logic [eq_loop_pkg::EQ_W-1:0] eq_manual_setting,
  input wire logic first_port_adapt_load,
  input wire logic second_port_adapt_load,
  input wire logic [LINK_W-1:0] loop_through_output,
  input wire logic monitor_driver_on,
  input wire logic monitor_tx_sleep
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Skip the first edge after reset, outputs still hold their reset zeros
  a_auto_vs_manual: assert property ($past(presetn) |-> eq_auto_run != eq_manual_apply)
    else $error("auto and manual flags agree");
  a_manual_zero_auto: assert property (eq_auto_run |-> eq_manual_setting == '0)
    else $error("manual setting applied while auto runs");
  a_sleep_mutes_driver: assert property (monitor_tx_sleep |-> !monitor_driver_on)
    else $error("driver on while transmitter sleeps");
  a_off_is_quiet: assert property (!monitor_driver_on |-> loop_through_output == '0)
    else $error("monitor output moves while driver off");
  a_source_is_link: assert property (monitor_driver_on && $past(monitor_driver_on) |->
    loop_through_output == $past(first_link_input) ||
    loop_through_output == $past(second_link_input))
    else $error("monitor output is neither link input");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_ready_follows: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait state");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  a_restart_loads: assert property ($rose(adaptation_restart) && eq_auto_run |->
    ##[1:2] (first_port_adapt_load && second_port_adapt_load))
    else $error("restart did not load both start levels");
  c_manual: cover property (eq_manual_apply);
  c_live: cover property (monitor_driver_on);
  c_refused: cover property (pslverr);
endmodule : eq_loop_properties

bind eq_and_loop_through_config eq_loop_properties #(.LINK_W(LINK_W)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .first_link_input(first_link_input),
  .second_link_input(second_link_input), .adaptation_restart(adaptation_restart),
  .eq_auto_run(eq_auto_run), .eq_manual_apply(eq_manual_apply),
  .eq_manual_setting(eq_manual_setting), .first_port_adapt_load(first_port_adapt_load),
  .second_port_adapt_load(second_port_adapt_load),
  .loop_through_output(loop_through_output), .monitor_driver_on(monitor_driver_on),
  .monitor_tx_sleep(monitor_tx_sleep)
);

/* tb/tb_top.sv */
// Purpose: Self-checking bench for the equalizer and loop-through bank
// Assumes: One wait state on APB, outputs follow the register one edge later
// Notes: Link inputs held steady so the monitor path is easy to predict
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_top;
  typedef struct {logic [7:0] idx; logic [7:0] rst; logic [7:0] wd;} row_s;
  typedef struct {logic [7:0] a; logic [7:0] b; logic on; logic [9:0] q;} mon_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, restart = 1'b0;
  logic [eq_loop_pkg::ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, er, auto_run, manual, ld1, ld2, drv_on, sleep;
  logic [5:0] setting;
  logic [3:0] lvl1, lvl2;
  logic [9:0] in1 = 10'h155, in2 = 10'h2AA, lt_out;
  int err_total = 0, cmp_count = 0, n;
  row_s rows[7] = '{'{8'h44, 8'h60, 8'hA6}, '{8'h45, 8'h88, 8'h5C}, '{8'h52, 8'h00, 8'h7F},
    '{8'h56, 8'h00, 8'hF7}, '{8'h57, 8'h00, 8'hF9}, '{8'h63, 8'h00, 8'hFE},
    '{8'h70, 8'h00, 8'h00}};
  mon_s mon[5] = '{'{8'h00, 8'h02, 1'b1, 10'h155}, '{8'h80, 8'h04, 1'b1, 10'h2AA},
    '{8'h00, 8'h04, 1'b0, 10'h000}, '{8'h80, 8'h06, 1'b0, 10'h000},
    '{8'h80, 8'h04, 1'b1, 10'h2AA}};

  always #12.5 pclk = ~pclk;

  eq_and_loop_through_config #(.LINK_W(10)) dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_link_input(in1), .second_link_input(in2), .adaptation_restart(restart),
    .eq_auto_run(auto_run), .eq_manual_apply(manual), .eq_manual_setting(setting),
    .first_port_start_level(lvl1), .second_port_start_level(lvl2),
    .first_port_adapt_load(ld1), .second_port_adapt_load(ld2), .loop_through_output(lt_out),
    .monitor_driver_on(drv_on), .monitor_tx_sleep(sleep)
  );

  function automatic logic [11:0] ba(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction : ba

  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  // Holds the request until pready is seen high; a missing answer ends the run
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      err_total++;
      final_report();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      apb(1'b0, ba(rows[i].idx), 8'h00);
      `CHK(rd, {24'h0, rows[i].rst})
      apb(1'b1, ba(rows[i].idx), rows[i].wd);
      apb(1'b0, ba(rows[i].idx), 8'h00);
      `CHK({er, rd}, {25'h0, rows[i].wd})
    end
    $display("test registers done");
    apb(1'b0, ba(8'h60), 8'h00);
    `CHK({er, rd}, 33'h100000000)
    apb(1'b1, ba(8'h44) + 12'h1, 8'hA7);
    `CHK(er, 1'b1)
    apb(1'b1, ba(8'h71), 8'hFF);
    `CHK(er, 1'b1)
    apb(1'b0, ba(8'h44), 8'h00);
    `CHK(rd, 32'h000000A6)
    $display("test refusals done");
    apb(1'b1, ba(8'h44), 8'hA7);
    repeat (2) @(posedge pclk);
    `CHK({auto_run, manual, setting}, 8'h6B)
    apb(1'b1, ba(8'h44), 8'hA6);
    repeat (2) @(posedge pclk);
    `CHK({auto_run, manual, setting}, 8'h80)
    $display("test override done");
    apb(1'b1, ba(8'h56), 8'h08);
    foreach (mon[i]) begin
      apb(1'b1, ba(8'h52), mon[i].a);
      apb(1'b1, ba(8'h57), mon[i].b);
      repeat (2) @(posedge pclk);
      `CHK({drv_on, lt_out}, {mon[i].on, mon[i].q})
    end
    apb(1'b1, ba(8'h63), 8'h01);
    repeat (2) @(posedge pclk);
    `CHK({sleep, drv_on}, 2'h2)
    apb(1'b1, ba(8'h63), 8'h00);
    repeat (2) @(posedge pclk);
    `CHK({sleep, drv_on}, 2'h1)
    apb(1'b1, ba(8'h56), 8'h00);
    repeat (2) @(posedge pclk);
    `CHK(drv_on, 1'b0)
    $display("test monitor done");
    apb(1'b1, ba(8'h70), 8'h01);
    apb(1'b1, ba(8'h45), 8'h03);
    repeat (2) @(posedge pclk);
    `CHK({lvl1, lvl2}, 8'hC3)
    restart <= 1'b1;
    @(posedge pclk);
    restart <= 1'b0;
    n = 0;
    while (ld1 !== 1'b1 && n < 4) begin
      @(posedge pclk);
      n++;
    end
    `CHK({ld1, ld2}, 2'h3)
    $display("test start level done");
    // Reset in mid-run must bring back the printed values
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK({lvl1, lvl2, auto_run, drv_on}, 10'h222)
    apb(1'b0, ba(8'h45), 8'h00);
    `CHK(rd, 32'h00000088)
    apb(1'b0, ba(8'h71), 8'h00);
    `CHK({er, rd}, 33'h000000005)
    $display("test reset done");
    final_report();
  end
endmodule : tb_top
